// >>> logic/sna_alu.sv
// Execution datapath for file-minus-accumulator, literal-minus-accumulator
// and nibble swap. Assumes an external sequencer presents one instruction
// per four-phase cycle and returns the file register value during Q2.
`timescale 1ns/1ps
module sna_alu
    import sna_pkg::*;
(
    // Clock and control.
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    // Instruction, latched at Q1.
    input  wire logic [INSN_W-1:0] insn,
    input  wire logic              insn_valid,
    // Operand sources.
    input  wire logic [DATA_W-1:0] acc_value,
    input  wire logic [DATA_W-1:0] file_rdata,
    // File read request.
    output logic                   file_re_ff,
    output logic [ADDR_W-1:0]      file_raddr_ff,
    // Write-back.
    output sna_wb_s                wb_ff,
    output sna_flags_s             flags_ff,
    output logic [1:0]             phase_ff
);
    sna_phase_e        state_ff;
    sna_phase_e        nxt_state;
    sna_op_e           op_ff;
    sna_op_e           nxt_op;
    logic              dest_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] lit_ff;
    logic [DATA_W-1:0] opnd_ff;

    wire logic [5:0]        opc6;
    wire logic              dec_dest;
    wire logic [ADDR_W-1:0] dec_addr;
    wire logic [DATA_W-1:0] diff;
    wire logic [DATA_W-1:0] swapped;
    wire logic [DATA_W-1:0] minuend;
    wire sna_flags_s        xflags;
    wire logic              is_sub;
    wire logic              to_file;
    wire sna_wb_s           wb_q4;

    assign opc6     = insn[OPC_HI:OPC_LO];
    assign dec_dest = insn[DEST_BIT];
    assign dec_addr = insn[ADDR_HI:0];
    assign nxt_op   = !insn_valid                       ? SNA_OP_NONE
                    : (opc6 == OPC_SUB_F)                ? SNA_OP_SUB_F
                    : (opc6 == OPC_SWAP_F)               ? SNA_OP_SWAP
                    : (opc6[5:1] == OPC_SUB_L)           ? SNA_OP_SUB_L
                    : SNA_OP_NONE;

    always_comb begin
        case (state_ff)
            SNA_Q1:  nxt_state = SNA_Q2;
            SNA_Q2:  nxt_state = SNA_Q3;
            SNA_Q3:  nxt_state = SNA_Q4;
            SNA_Q4:  nxt_state = SNA_Q1;
            default: nxt_state = SNA_Q1;
        endcase
    end

    // The literal operand replaces the file read for the literal form.
    assign minuend = (op_ff == SNA_OP_SUB_L) ? lit_ff : opnd_ff;
    assign is_sub  = (op_ff == SNA_OP_SUB_F) || (op_ff == SNA_OP_SUB_L);
    // Literal subtract always lands in the accumulator.
    assign to_file = dest_ff && (op_ff != SNA_OP_SUB_L);

    sna_exec #(
        .W (DATA_W)
    ) u_exec (
        .minuend    (minuend),
        .subtrahend (acc_value),
        .swap_src   (opnd_ff),
        .diff       (diff),
        .swapped    (swapped),
        .flags      (xflags)
    );

    assign wb_q4.acc_we    = (op_ff != SNA_OP_NONE) && !to_file;
    assign wb_q4.file_we   = (op_ff != SNA_OP_NONE) && to_file;
    assign wb_q4.flags_we  = is_sub;
    assign wb_q4.file_addr = addr_ff;
    // The result is formed in Q3 and registered at the Q3 edge, so a
    // strobe and its data always reach Q4 together.
    assign wb_q4.data      = is_sub ? diff : swapped;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= SNA_Q1;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // Q1 decode.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            op_ff   <= SNA_OP_NONE;
            dest_ff <= 1'b0;
            addr_ff <= RST_ADDR;
            lit_ff  <= RST_DATA;
        end else if (clk_en && state_ff == SNA_Q1) begin
            op_ff   <= nxt_op;
            dest_ff <= dec_dest;
            addr_ff <= dec_addr;
            lit_ff  <= insn[DATA_W-1:0];
        end
    end

    // Q2 read; Q3 processing is combinational and lands in wb_ff.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            opnd_ff <= RST_DATA;
        end else if (clk_en && state_ff == SNA_Q2) begin
            opnd_ff <= file_rdata;
        end
    end

    // Q4 write; strobes last exactly the one Q4 phase.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_ff         <= '0;
            flags_ff      <= '0;
            file_re_ff    <= 1'b0;
            file_raddr_ff <= RST_ADDR;
            phase_ff      <= RST_PHASE;
        end else if (clk_en) begin
            phase_ff      <= 2'(nxt_state);
            file_re_ff    <= (state_ff == SNA_Q1) && (nxt_op == SNA_OP_SUB_F
                             || nxt_op == SNA_OP_SWAP);
            file_raddr_ff <= (state_ff == SNA_Q1) ? dec_addr : file_raddr_ff;
            wb_ff         <= (state_ff == SNA_Q3) ? wb_q4 : '0;
            if (state_ff == SNA_Q3 && is_sub) begin
                flags_ff <= xflags;
            end
        end
    end

    // Checks.
    a_swap_keeps_flags: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && op_ff == SNA_OP_SWAP)
        |=> $stable(flags_ff))
        else $error("flags changed on swap");
    a_zero_sets_carry: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wb_ff.flags_we && wb_ff.data == 8'h00)
        |-> (flags_ff.zero && flags_ff.carry))
        else $error("zero result flags wrong");
    a_nonzero_clears_z: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wb_ff.flags_we && wb_ff.data != 8'h00) |-> !flags_ff.zero)
        else $error("zero flag set on nonzero result");
    a_sub_result_value: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && is_sub)
        |=> wb_ff.data == 8'($past(minuend) - $past(acc_value)))
        else $error("subtract result wrong");
    a_borrow_clr_carry: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && is_sub && minuend < acc_value)
        |=> !flags_ff.carry)
        else $error("carry set on borrow");
    a_dc_nibble_sense: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && is_sub)
        |=> flags_ff.digit_carry_flag
            == ($past(minuend[3:0]) >= $past(acc_value[3:0])))
        else $error("digit carry wrong");
    a_dest_routing: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && op_ff == SNA_OP_SUB_F && dest_ff)
        |=> wb_ff.file_we && !wb_ff.acc_we && wb_ff.file_addr == addr_ff)
        else $error("destination routing wrong");
    a_literal_to_acc: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && op_ff == SNA_OP_SUB_L)
        |=> wb_ff.acc_we && !wb_ff.file_we)
        else $error("literal result not to accumulator");
    a_swap_value: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && op_ff == SNA_OP_SWAP)
        |=> wb_ff.data == {$past(opnd_ff[3:0]), $past(opnd_ff[7:4])})
        else $error("swap result wrong");
    a_addr_captured: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q1) |=> addr_ff == $past(insn[6:0]))
        else $error("address decode wrong");
    a_enable_freeze: assert property (
        @(posedge ref_clk) disable iff (rst)
        !clk_en |=> $stable(state_ff) && $stable(wb_ff)
            && $stable(flags_ff))
        else $error("state moved while clock enable low");
    a_strobe_q4_only: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wb_ff.acc_we || wb_ff.file_we || wb_ff.flags_we)
        |-> phase_ff == 2'h3)
        else $error("write strobe outside Q4");
    a_read_in_q2: assert property (
        @(posedge ref_clk) disable iff (rst)
        file_re_ff |-> phase_ff == 2'h1)
        else $error("file read outside Q2");
    a_read_addr_match: assert property (
        @(posedge ref_clk) disable iff (rst)
        file_re_ff |-> file_raddr_ff == addr_ff)
        else $error("read address differs from decoded address");
    a_acc_dest_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && op_ff != SNA_OP_NONE && !dest_ff)
        |=> wb_ff.acc_we && !wb_ff.file_we)
        else $error("destination zero not routed to accumulator");
    a_swap_no_flag_we: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && op_ff == SNA_OP_SWAP)
        |=> !wb_ff.flags_we)
        else $error("flag write on swap");
    a_positive_sets_c: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && is_sub && minuend > acc_value)
        |=> flags_ff.carry && !flags_ff.zero)
        else $error("positive result flags wrong");
    a_phase_follows: assert property (
        @(posedge ref_clk) disable iff (rst)
        clk_en |=> phase_ff == 2'($past(phase_ff) + 2'h1))
        else $error("phase did not advance");
    a_no_op_quiet: assert property (
        @(posedge ref_clk) disable iff (rst)
        (clk_en && state_ff == SNA_Q3 && op_ff == SNA_OP_NONE)
        |=> !wb_ff.acc_we && !wb_ff.file_we && !wb_ff.flags_we)
        else $error("strobe on an idle cycle");

endmodule : sna_alu

// >>> logic/sna_exec.sv
// Arithmetic core: subtraction with borrow flags, and nibble swap.
// Purely combinational; the caller registers everything it uses.
`timescale 1ns/1ps
module sna_exec
    import sna_pkg::*;
#(
    parameter int unsigned W = DATA_W
) (
    // Operands.
    input  wire logic [W-1:0] minuend,
    input  wire logic [W-1:0] subtrahend,
    input  wire logic [W-1:0] swap_src,
    // Results.
    output wire logic [W-1:0] diff,
    output wire logic [W-1:0] swapped,
    output sna_flags_s        flags
);
    wire logic [W:0]   full_diff;
    wire logic [NIB_W:0] low_diff;

    // Two's complement subtract; the extra bit is the inverted borrow.
    assign full_diff = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, 1'b1};
    assign low_diff  = {1'b0, minuend[NIB_W-1:0]}
                     + {1'b0, ~subtrahend[NIB_W-1:0]}
                     + {{NIB_W{1'b0}}, 1'b1};
    assign diff      = full_diff[W-1:0];
    assign flags = '{carry:            full_diff[W],
                     digit_carry_flag: low_diff[NIB_W],
                     zero:             (full_diff[W-1:0] == '0)};
    assign swapped   = {swap_src[NIB_W-1:0], swap_src[W-1:NIB_W]};

endmodule : sna_exec

// >>> logic/sna_pkg.sv
// Package for the subtract and nibble-swap execution datapath.
// Assumes a 14-bit instruction word and a four-phase instruction cycle.
package sna_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned INSN_W = 14;

    // Opcode field positions and values.
    localparam int unsigned OPC_HI      = 13;
    localparam int unsigned OPC_LO      = 8;
    localparam logic [5:0]  OPC_SUB_F   = 6'h02;
    localparam logic [5:0]  OPC_SWAP_F  = 6'h0e;
    localparam logic [4:0]  OPC_SUB_L   = 5'h1e;
    localparam int unsigned DEST_BIT    = 7;
    localparam int unsigned ADDR_HI     = 6;
    localparam int unsigned NIB_W       = 4;

    // Values after reset.
    localparam logic [7:0]  RST_DATA    = 8'h00;
    localparam logic [6:0]  RST_ADDR    = 7'h00;
    localparam logic [1:0]  RST_PHASE   = 2'h0;

    typedef enum logic [1:0] {
        SNA_OP_NONE,
        SNA_OP_SUB_F,
        SNA_OP_SUB_L,
        SNA_OP_SWAP
    } sna_op_e;

    typedef enum {
        SNA_Q1,
        SNA_Q2,
        SNA_Q3,
        SNA_Q4
    } sna_phase_e;

    // Flags as the datapath reports them.
    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } sna_flags_s;

    // Write-back to the register file or accumulator.
    typedef struct packed {
        logic       acc_we;
        logic       file_we;
        logic       flags_we;
        logic [6:0] file_addr;
        logic [7:0] data;
    } sna_wb_s;

endpackage : sna_pkg

// >>> test/sna_alu_tb.sv
// Self-checking bench for the subtract and nibble-swap datapath.
// Assumes the package and datapath modules are compiled before this file.
`timescale 1ns/1ps
module subtract_and_nibble_swap_alu_tb_top;
    import sna_pkg::*;

    logic              ref_clk    = 1'b0;
    logic              rst        = 1'b1;
    logic              clk_en     = 1'b1;
    logic [INSN_W-1:0] insn       = '0;
    logic              insn_valid = 1'b0;
    logic [DATA_W-1:0] acc_value  = '0;
    logic [DATA_W-1:0] file_rdata = '0;
    logic              file_re_ff;
    logic [ADDR_W-1:0] file_raddr_ff;
    sna_wb_s           wb_ff;
    sna_flags_s        flags_ff;
    logic [1:0]        phase_ff;
    sna_flags_s        exp_flags  = '0;
    int                error_cnt  = 0;
    int                checked    = 0;

    always #2.5 ref_clk = ~ref_clk;

    sna_alu sna_alu_inst (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .clk_en        (clk_en),
        .insn          (insn),
        .insn_valid    (insn_valid),
        .acc_value     (acc_value),
        .file_rdata    (file_rdata),
        .file_re_ff    (file_re_ff),
        .file_raddr_ff (file_raddr_ff),
        .wb_ff         (wb_ff),
        .flags_ff      (flags_ff),
        .phase_ff      (phase_ff)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    // Kind: 1 file subtract, 2 literal subtract, 3 swap, 0 no operation.
    function automatic logic [1:0] kind_of(input logic [13:0] w,
                                           input logic v);
        if (!v) return 2'h0;
        if (w[OPC_HI:OPC_LO] == OPC_SUB_F) return 2'h1;
        if (w[OPC_HI:OPC_LO+1] == OPC_SUB_L) return 2'h2;
        if (w[OPC_HI:OPC_LO] == OPC_SWAP_F) return 2'h3;
        return 2'h0;
    endfunction : kind_of

    // Called at a rising edge; the next cycle is Q1 of this instruction.
    task automatic run(input logic [13:0] w, input logic v,
                       input logic [7:0] a, input logic [7:0] f,
                       input int unsigned stall);
        logic [1:0] k;
        logic [7:0] m;
        logic [7:0] res;
        k = kind_of(w, v);
        m = (k == 2'h2) ? w[7:0] : f;
        res = (k == 2'h3) ? {f[3:0], f[7:4]} : m - a;
        if (k == 2'h1 || k == 2'h2) begin
            exp_flags = '{m >= a, m[3:0] >= a[3:0], res == 8'h00};
        end
        insn <= w;
        insn_valid <= v;
        acc_value <= a;
        file_rdata <= f;
        @(posedge ref_clk);
        if (stall != 0) clk_en <= 1'b0;
        #1;
        check(phase_ff, 2'h1);
        if (k[0]) begin
            check(file_re_ff, 1'b1);
            check(file_raddr_ff, w[6:0]);
        end
        // A low clock enable in Q2 must hold every output where it stands.
        if (stall != 0) begin
            repeat (stall) @(posedge ref_clk);
            clk_en <= 1'b1;
            #1;
            check(phase_ff, 2'h1);
            check(file_re_ff, k[0]);
            check(wb_ff, '0);
        end
        repeat (2) @(posedge ref_clk);
        #1;
        check(phase_ff, 2'h3);
        check(wb_ff.acc_we, k == 2'h2 || (k[0] && !w[7]));
        check(wb_ff.file_we, k[0] && w[7]);
        check(wb_ff.flags_we, k == 2'h1 || k == 2'h2);
        if (k != 2'h0) check(wb_ff.data, res);
        if (k[0] && w[7]) check(wb_ff.file_addr, w[6:0]);
        check(flags_ff, exp_flags);
        $display("test of word %h ended at %0t", w, $time);
        @(posedge ref_clk);
    endtask : run

    initial begin
        logic [13:0] w;
        void'($urandom(32876));
        repeat (11) @(posedge ref_clk);
        #1;
        check(phase_ff, 2'h0);
        check(wb_ff, '0);
        check(flags_ff, '0);
        @(posedge ref_clk);
        rst <= 1'b0;
        run(14'h3c02, 1'b1, 8'h01, 8'h00, 0);
        run(14'h3c02, 1'b1, 8'h02, 8'h00, 1);
        run(14'h3c02, 1'b1, 8'h03, 8'h00, 0);
        run(14'h02a5, 1'b1, 8'h02, 8'h03, 2);
        run(14'h0225, 1'b1, 8'h02, 8'h02, 0);
        run(14'h02ff, 1'b1, 8'h02, 8'h01, 0);
        run(14'h0e25, 1'b1, 8'h00, 8'ha5, 1);
        run(14'h0eff, 1'b1, 8'h00, 8'h3c, 0);
        run(14'h0200, 1'b1, 8'h01, 8'h10, 0);
        run(14'h0200, 1'b0, 8'h01, 8'h05, 1);
        run(14'h3fff, 1'b1, 8'h01, 8'h05, 0);
        // Random traffic, back to back, over all three operations.
        for (int i = 0; i < 48; i++) begin
            case ($urandom % 3)
                0: w = {OPC_SUB_F, 8'($urandom)};
                1: w = {OPC_SWAP_F, 8'($urandom)};
                default: w = {OPC_SUB_L, 9'($urandom)};
            endcase
            run(w, 1'b1, 8'($urandom), 8'($urandom), $urandom % 3);
        end
        wrap_up();
    end

    // The tests need under 400 cycles; this allows ten times that.
    initial begin
        #20000;
        error_cnt++;
        wrap_up();
    end
endmodule : subtract_and_nibble_swap_alu_tb_top
